// ===== hw/dspb_bank.v
// APB register bank holding drive setpoint parameters and the combined target
//
// Function
// (R01) Both frequency source selectors accept codes 0 to 7 only.
// (R02) Combine operator: 0 adds, 1 subtracts second from first, 2 multiplies.
// (R03) Added frequency offset holds 0 to 40000, split high then low word.
// (R04) Offset sign 0 adds offset to command, 1 subtracts it.
// (R05) Deceleration curve accepts acceleration curve codes, 4 meaning EL-S curve.
// (R06) Acceleration and deceleration curve constants accept 1 to 10.
// (R07) Four EL-S ratio registers accept 0 to 50 percent.
// (R08) Current input start and end frequencies hold 0 to 40000 as word pairs.
// (R09) Current input start and end percentages within 0 to 100, start not above end.
// (R10) Current input start select: 0 external start frequency, 1 start at 0 Hz.
// (R11) Bipolar input start and end frequencies hold signed -40000 to 40000 pairs.
// (R12) Bipolar input percentages within -100 to 100, start not above end.
// (R13) Out of range writes and reserved addresses leave parameters unchanged.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dspb_defs.vh"

module dspb_bank (
  // Clock, reset and enable
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Frequencies of the two selected sources
  input  wire [15:0] src_first_freq,
  input  wire [15:0] src_second_freq,
  // Combined target frequency
  output wire [33:0] target_freq,
  // Parameter outputs
  output wire [2:0]  decel_curve_shape,
  output wire [31:0] cur_in_start_freq,
  output wire [31:0] cur_in_end_freq,
  output wire [6:0]  cur_in_start_pct,
  output wire [6:0]  cur_in_end_pct,
  output wire        cur_in_start_freq_select,
  output wire [31:0] bipolar_in_start_freq,
  output wire [31:0] bipolar_in_end_freq,
  output wire [15:0] bipolar_in_start_pct,
  output wire [15:0] bipolar_in_end_pct,
  output wire [3:0]  accel_curve_constant,
  output wire [3:0]  decel_curve_constant,
  output wire [2:0]  freq_source_first,
  output wire [2:0]  freq_source_second,
  output wire [1:0]  source_combine_op,
  output wire [31:0] added_freq_offset,
  output wire        added_freq_sign,
  output wire [5:0]  els_ratio_one,
  output wire [5:0]  els_ratio_two,
  output wire [5:0]  els_decel_ratio_one,
  output wire [5:0]  els_decel_ratio_two
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function [4:0] slot_of;
    input [13:0] ix;
    begin
      case (ix)
        `DSPB_IX_DECEL_SHAPE: slot_of = `DSPB_S_DECEL_SHAPE;
        `DSPB_IX_CUR_SF_HI:   slot_of = `DSPB_S_CUR_SF_HI;
        `DSPB_IX_CUR_SF_LO:   slot_of = `DSPB_S_CUR_SF_LO;
        `DSPB_IX_CUR_EF_HI:   slot_of = `DSPB_S_CUR_EF_HI;
        `DSPB_IX_CUR_EF_LO:   slot_of = `DSPB_S_CUR_EF_LO;
        `DSPB_IX_CUR_SPCT:    slot_of = `DSPB_S_CUR_SPCT;
        `DSPB_IX_CUR_EPCT:    slot_of = `DSPB_S_CUR_EPCT;
        `DSPB_IX_CUR_SF_SEL:  slot_of = `DSPB_S_CUR_SF_SEL;
        `DSPB_IX_BIP_SF_HI:   slot_of = `DSPB_S_BIP_SF_HI;
        `DSPB_IX_BIP_SF_LO:   slot_of = `DSPB_S_BIP_SF_LO;
        `DSPB_IX_BIP_EF_HI:   slot_of = `DSPB_S_BIP_EF_HI;
        `DSPB_IX_BIP_EF_LO:   slot_of = `DSPB_S_BIP_EF_LO;
        `DSPB_IX_BIP_SPCT:    slot_of = `DSPB_S_BIP_SPCT;
        `DSPB_IX_BIP_EPCT:    slot_of = `DSPB_S_BIP_EPCT;
        `DSPB_IX_ACC_CONST:   slot_of = `DSPB_S_ACC_CONST;
        `DSPB_IX_DEC_CONST:   slot_of = `DSPB_S_DEC_CONST;
        `DSPB_IX_SRC_FIRST:   slot_of = `DSPB_S_SRC_FIRST;
        `DSPB_IX_SRC_SECOND:  slot_of = `DSPB_S_SRC_SECOND;
        `DSPB_IX_COMBINE_OP:  slot_of = `DSPB_S_COMBINE_OP;
        `DSPB_IX_ADD_HI:      slot_of = `DSPB_S_ADD_HI;
        `DSPB_IX_ADD_LO:      slot_of = `DSPB_S_ADD_LO;
        `DSPB_IX_ADD_SIGN:    slot_of = `DSPB_S_ADD_SIGN;
        `DSPB_IX_ELS_R1:      slot_of = `DSPB_S_ELS_R1;
        `DSPB_IX_ELS_R2:      slot_of = `DSPB_S_ELS_R2;
        `DSPB_IX_ELS_DR1:     slot_of = `DSPB_S_ELS_DR1;
        `DSPB_IX_ELS_DR2:     slot_of = `DSPB_S_ELS_DR2;
        default:              slot_of = `DSPB_S_NONE; // R13
      endcase
    end
  endfunction

  // High word of a 32-bit pair; its low word sits in the next slot
  function is_hi;
    input [4:0] s;
    begin
      is_hi = (s == `DSPB_S_CUR_SF_HI) || (s == `DSPB_S_CUR_EF_HI) ||
              (s == `DSPB_S_BIP_SF_HI) || (s == `DSPB_S_BIP_EF_HI) ||
              (s == `DSPB_S_ADD_HI);
    end
  endfunction

  function is_lo;
    input [4:0] s;
    begin
      is_lo = is_hi(s - 5'h01) && (s != `DSPB_S_DECEL_SHAPE);
    end
  endfunction

  function [15:0] rst_val;
    input [4:0] s;
    begin
      case (s)
        `DSPB_S_CUR_EPCT, `DSPB_S_BIP_EPCT:   rst_val = `DSPB_RST_PCT_END;
        `DSPB_S_BIP_SPCT:                     rst_val = `DSPB_RST_BIP_PCT_START;
        `DSPB_S_ACC_CONST, `DSPB_S_DEC_CONST: rst_val = `DSPB_RST_CONST;
        default:                              rst_val = `DSPB_RST_ZERO;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and checking

  reg  [15:0] regs_q [0:`DSPB_NREG-1];
  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;
  reg  [15:0] pend_q;
  reg  [4:0]  pend_slot_q;
  reg         pend_vld_q;
  reg  [33:0] target_q;

  // Address must be word aligned to hit a register
  wire [4:0]  slot = (paddr[1:0] == 2'h0) ? slot_of(paddr[15:2]) : `DSPB_S_NONE;
  wire        hit = (slot != `DSPB_S_NONE);
  wire        access = psel && penable && !pready_q;
  wire        done = psel && penable && pready_q;
  wire [15:0] wdata = pwdata[15:0];
  wire        pend_match = pend_vld_q && (pend_slot_q == slot - 5'h01);
  // A low word pairs with the staged high word, else the stored one
  wire [15:0] hi_word = pend_match ? pend_q : regs_q[slot - 5'h01];
  wire        wr_ok;

  dspb_wchk u_wchk (
    .slot     (slot),
    .wdata    (wdata),
    .hi_word  (hi_word),
    .cur_spct (regs_q[`DSPB_S_CUR_SPCT]),
    .cur_epct (regs_q[`DSPB_S_CUR_EPCT]),
    .bip_spct (regs_q[`DSPB_S_BIP_SPCT]),
    .bip_epct (regs_q[`DSPB_S_BIP_EPCT]),
    .ok       (wr_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: answer one cycle into the access phase

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (ce) begin
      if (access) begin
        pready_q  <= 1'b1;
        pslverr_q <= !hit || (pwrite && !wr_ok); // R13
        prdata_q  <= (hit && !pwrite) ? {16'h0000, regs_q[slot]} : 32'h00000000;
      end else begin
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  // High words are staged and committed only with a valid low word, so a
  // pair never shows a half-updated value that lies outside its range.

  wire commit = done && pwrite && !pslverr_q;

  genvar g;
  generate
    for (g = 0; g < `DSPB_NREG; g = g + 1) begin : g_reg
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_q[g] <= rst_val(g[4:0]);
        end else if (ce && commit) begin
          if (slot == g[4:0] && !is_hi(slot)) begin
            regs_q[g] <= wdata; // R13
          end else if (is_lo(slot) && slot == g[4:0] + 5'h01) begin
            regs_q[g] <= hi_word; // R03 R08 R11
          end
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q      <= `DSPB_RST_ZERO;
      pend_slot_q <= `DSPB_S_NONE;
      pend_vld_q  <= 1'b0;
    end else if (ce && done && pwrite) begin
      if (!pslverr_q && is_hi(slot)) begin
        pend_q      <= wdata;
        pend_slot_q <= slot;
        pend_vld_q  <= 1'b1;
      end else if (is_lo(slot) && pend_match) begin
        // Accepted or refused, the staged high word is used up
        pend_vld_q  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target frequency from the two sources and the offset

  wire [31:0] add_off = {regs_q[`DSPB_S_ADD_HI], regs_q[`DSPB_S_ADD_LO]};
  reg  [33:0] comb_d;
  reg  [33:0] target_d;

  always @* begin
    case (regs_q[`DSPB_S_COMBINE_OP][1:0])
      `DSPB_OP_ADD: comb_d = {18'h00000, src_first_freq} + {18'h00000, src_second_freq}; // R02
      `DSPB_OP_SUB: comb_d = {18'h00000, src_first_freq} - {18'h00000, src_second_freq}; // R02
      `DSPB_OP_MUL: comb_d = {18'h00000, src_first_freq} * {18'h00000, src_second_freq}; // R02
      default:      comb_d = 34'h000000000;
    endcase
    if (regs_q[`DSPB_S_ADD_SIGN][0] == `DSPB_SIGN_SUB) begin
      target_d = comb_d - {2'h0, add_off}; // R04
    end else begin
      target_d = comb_d + {2'h0, add_off}; // R04
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_q <= 34'h000000000;
    end else if (ce) begin
      target_q <= target_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata                   = prdata_q;
  assign pready                   = pready_q;
  assign pslverr                  = pslverr_q;
  assign target_freq              = target_q;
  assign decel_curve_shape        = regs_q[`DSPB_S_DECEL_SHAPE][2:0];
  assign cur_in_start_freq        = {regs_q[`DSPB_S_CUR_SF_HI], regs_q[`DSPB_S_CUR_SF_LO]};
  assign cur_in_end_freq          = {regs_q[`DSPB_S_CUR_EF_HI], regs_q[`DSPB_S_CUR_EF_LO]};
  assign cur_in_start_pct         = regs_q[`DSPB_S_CUR_SPCT][6:0];
  assign cur_in_end_pct           = regs_q[`DSPB_S_CUR_EPCT][6:0];
  assign cur_in_start_freq_select = regs_q[`DSPB_S_CUR_SF_SEL][0];
  assign bipolar_in_start_freq    = {regs_q[`DSPB_S_BIP_SF_HI], regs_q[`DSPB_S_BIP_SF_LO]};
  assign bipolar_in_end_freq      = {regs_q[`DSPB_S_BIP_EF_HI], regs_q[`DSPB_S_BIP_EF_LO]};
  assign bipolar_in_start_pct     = regs_q[`DSPB_S_BIP_SPCT];
  assign bipolar_in_end_pct       = regs_q[`DSPB_S_BIP_EPCT];
  assign accel_curve_constant     = regs_q[`DSPB_S_ACC_CONST][3:0];
  assign decel_curve_constant     = regs_q[`DSPB_S_DEC_CONST][3:0];
  assign freq_source_first        = regs_q[`DSPB_S_SRC_FIRST][2:0];
  assign freq_source_second       = regs_q[`DSPB_S_SRC_SECOND][2:0];
  assign source_combine_op        = regs_q[`DSPB_S_COMBINE_OP][1:0];
  assign added_freq_offset        = add_off;
  assign added_freq_sign          = regs_q[`DSPB_S_ADD_SIGN][0];
  assign els_ratio_one            = regs_q[`DSPB_S_ELS_R1][5:0];
  assign els_ratio_two            = regs_q[`DSPB_S_ELS_R2][5:0];
  assign els_decel_ratio_one      = regs_q[`DSPB_S_ELS_DR1][5:0];
  assign els_decel_ratio_two      = regs_q[`DSPB_S_ELS_DR2][5:0];

endmodule
`default_nettype wire

// ===== hw/dspb_defs.vh
// Register map, limits and reset values of the drive setpoint parameter bank
`ifndef DSPB_DEFS_VH
`define DSPB_DEFS_VH

// Register indices (byte address is four times the index)
`define DSPB_IX_DECEL_SHAPE     14'h127e
`define DSPB_IX_CUR_SF_HI       14'h1281
`define DSPB_IX_CUR_SF_LO       14'h1282
`define DSPB_IX_CUR_EF_HI       14'h1283
`define DSPB_IX_CUR_EF_LO       14'h1284
`define DSPB_IX_CUR_SPCT        14'h1285
`define DSPB_IX_CUR_EPCT        14'h1286
`define DSPB_IX_CUR_SF_SEL      14'h1287
`define DSPB_IX_BIP_SF_HI       14'h128d
`define DSPB_IX_BIP_SF_LO       14'h128e
`define DSPB_IX_BIP_EF_HI       14'h128f
`define DSPB_IX_BIP_EF_LO       14'h1290
`define DSPB_IX_BIP_SPCT        14'h1291
`define DSPB_IX_BIP_EPCT        14'h1292
`define DSPB_IX_ACC_CONST       14'h12a5
`define DSPB_IX_DEC_CONST       14'h12a6
`define DSPB_IX_SRC_FIRST       14'h12af
`define DSPB_IX_SRC_SECOND      14'h12b0
`define DSPB_IX_COMBINE_OP      14'h12b1
`define DSPB_IX_ADD_HI          14'h12b3
`define DSPB_IX_ADD_LO          14'h12b4
`define DSPB_IX_ADD_SIGN        14'h12b5
`define DSPB_IX_ELS_R1          14'h12b9
`define DSPB_IX_ELS_R2          14'h12ba
`define DSPB_IX_ELS_DR1         14'h12bb
`define DSPB_IX_ELS_DR2         14'h12bc

// Storage slots
`define DSPB_NREG               26
`define DSPB_S_DECEL_SHAPE      5'h00
`define DSPB_S_CUR_SF_HI        5'h01
`define DSPB_S_CUR_SF_LO        5'h02
`define DSPB_S_CUR_EF_HI        5'h03
`define DSPB_S_CUR_EF_LO        5'h04
`define DSPB_S_CUR_SPCT         5'h05
`define DSPB_S_CUR_EPCT         5'h06
`define DSPB_S_CUR_SF_SEL       5'h07
`define DSPB_S_BIP_SF_HI        5'h08
`define DSPB_S_BIP_SF_LO        5'h09
`define DSPB_S_BIP_EF_HI        5'h0a
`define DSPB_S_BIP_EF_LO        5'h0b
`define DSPB_S_BIP_SPCT         5'h0c
`define DSPB_S_BIP_EPCT         5'h0d
`define DSPB_S_ACC_CONST        5'h0e
`define DSPB_S_DEC_CONST        5'h0f
`define DSPB_S_SRC_FIRST        5'h10
`define DSPB_S_SRC_SECOND       5'h11
`define DSPB_S_COMBINE_OP       5'h12
`define DSPB_S_ADD_HI           5'h13
`define DSPB_S_ADD_LO           5'h14
`define DSPB_S_ADD_SIGN         5'h15
`define DSPB_S_ELS_R1           5'h16
`define DSPB_S_ELS_R2           5'h17
`define DSPB_S_ELS_DR1          5'h18
`define DSPB_S_ELS_DR2          5'h19
`define DSPB_S_NONE             5'h1f

// Value limits
`define DSPB_MAX_CURVE          16'h0004
`define DSPB_MAX_FREQ           32'h00009c40
`define DSPB_MIN_FREQ_S         32'hffff63c0
`define DSPB_MAX_PCT            16'h0064
`define DSPB_MIN_PCT_S          16'hff9c
`define DSPB_MAX_BIT            16'h0001
`define DSPB_MIN_CONST          16'h0001
`define DSPB_MAX_CONST          16'h000a
`define DSPB_MAX_SOURCE         16'h0007
`define DSPB_MAX_OP             16'h0002
`define DSPB_MAX_RATIO          16'h0032

// Combine operator and sign codes
`define DSPB_OP_ADD             2'h0
`define DSPB_OP_SUB             2'h1
`define DSPB_OP_MUL             2'h2
`define DSPB_SIGN_SUB           1'h1

// Reset values
`define DSPB_RST_ZERO           16'h0000
`define DSPB_RST_PCT_END        16'h0064
`define DSPB_RST_BIP_PCT_START  16'hff9c
`define DSPB_RST_CONST          16'h0001

`endif

// ===== hw/dspb_wchk.v
// Write value range checker for the drive setpoint parameter bank
`timescale 1ns/1ps
`default_nettype none
`include "dspb_defs.vh"

module dspb_wchk (
  // Write being checked
  input  wire [4:0]  slot,
  input  wire [15:0] wdata,
  input  wire [15:0] hi_word,
  // Stored percentage pairs
  input  wire [15:0] cur_spct,
  input  wire [15:0] cur_epct,
  input  wire [15:0] bip_spct,
  input  wire [15:0] bip_epct,
  // Verdict
  output reg         ok
);

  wire [31:0] pair_u = {hi_word, wdata};
  wire signed [31:0] pair_s = {hi_word, wdata};
  wire signed [15:0] wd_s = wdata;

  always @* begin
    case (slot)
      `DSPB_S_DECEL_SHAPE: ok = (wdata <= `DSPB_MAX_CURVE); // R05
      `DSPB_S_CUR_SF_HI, `DSPB_S_CUR_EF_HI, `DSPB_S_BIP_SF_HI, `DSPB_S_BIP_EF_HI,
      `DSPB_S_ADD_HI: ok = 1'b1;
      `DSPB_S_CUR_SF_LO, `DSPB_S_CUR_EF_LO: ok = (pair_u <= `DSPB_MAX_FREQ); // R08
      `DSPB_S_ADD_LO: ok = (pair_u <= `DSPB_MAX_FREQ); // R03
      `DSPB_S_BIP_SF_LO, `DSPB_S_BIP_EF_LO: begin
        ok = (pair_s >= $signed(`DSPB_MIN_FREQ_S)) && (pair_s <= $signed(`DSPB_MAX_FREQ)); // R11
      end
      `DSPB_S_CUR_SPCT: ok = (wdata <= `DSPB_MAX_PCT) && (wdata <= cur_epct); // R09
      `DSPB_S_CUR_EPCT: ok = (wdata <= `DSPB_MAX_PCT) && (wdata >= cur_spct); // R09
      `DSPB_S_BIP_SPCT: begin
        ok = (wd_s >= $signed(`DSPB_MIN_PCT_S)) && (wd_s <= $signed(bip_epct)); // R12
      end
      `DSPB_S_BIP_EPCT: begin
        ok = (wd_s <= $signed(`DSPB_MAX_PCT)) && (wd_s >= $signed(bip_spct)); // R12
      end
      `DSPB_S_CUR_SF_SEL: ok = (wdata <= `DSPB_MAX_BIT); // R10
      `DSPB_S_ADD_SIGN: ok = (wdata <= `DSPB_MAX_BIT); // R04
      `DSPB_S_ACC_CONST, `DSPB_S_DEC_CONST: begin
        ok = (wdata >= `DSPB_MIN_CONST) && (wdata <= `DSPB_MAX_CONST); // R06
      end
      `DSPB_S_SRC_FIRST, `DSPB_S_SRC_SECOND: ok = (wdata <= `DSPB_MAX_SOURCE); // R01
      `DSPB_S_COMBINE_OP: ok = (wdata <= `DSPB_MAX_OP); // R02
      `DSPB_S_ELS_R1, `DSPB_S_ELS_R2, `DSPB_S_ELS_DR1, `DSPB_S_ELS_DR2: begin
        ok = (wdata <= `DSPB_MAX_RATIO); // R07
      end
      default: ok = 1'b0; // R13
    endcase
  end

endmodule
`default_nettype wire

// ===== testbench/dspb_bank_checker.sv
// Assertion checker for the drive setpoint parameter bank ports
`timescale 1ns/1ps
`default_nettype none
module dspb_bank_checker (
  // Clock, reset, enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Datapath
  input wire logic [15:0] src_first_freq,
  input wire logic [15:0] src_second_freq,
  input wire logic [33:0] target_freq,
  // Parameters
  input wire logic [2:0]  decel_curve_shape,
  input wire logic [31:0] cur_in_start_freq,
  input wire logic [6:0]  cur_in_start_pct,
  input wire logic [6:0]  cur_in_end_pct,
  input wire logic [15:0] bipolar_in_start_pct,
  input wire logic [15:0] bipolar_in_end_pct,
  input wire logic [3:0]  accel_curve_constant,
  input wire logic [1:0]  source_combine_op,
  input wire logic [31:0] added_freq_offset,
  input wire logic        added_freq_sign,
  input wire logic [5:0]  els_ratio_one
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic [33:0] tgt(input logic [1:0] op, input logic sg,
    input logic [15:0] a, input logic [15:0] b, input logic [31:0] o);
    logic [33:0] c;
    c = (op == 2'h0) ? {18'h0, a} + {18'h0, b} :
        (op == 2'h1) ? {18'h0, a} - {18'h0, b} : {18'h0, a} * {18'h0, b};
    tgt = sg ? c - {2'h0, o} : c + {2'h0, o};
  endfunction

  a_ready_wait: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_nodata: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_op_code: assert property (source_combine_op != 2'h3) else $error("bad op");
  a_target_calc: assert property (ce |=> target_freq == tgt($past(source_combine_op),
    $past(added_freq_sign), $past(src_first_freq), $past(src_second_freq),
    $past(added_freq_offset))) else $error("target mismatch");
  a_offset_range: assert property (added_freq_offset <= 32'h00009c40)
    else $error("offset out of range");
  a_shape_range: assert property (decel_curve_shape <= 3'h4) else $error("bad shape");
  a_const_range: assert property (accel_curve_constant >= 4'h1
    && accel_curve_constant <= 4'ha) else $error("bad constant");
  a_ratio_range: assert property (els_ratio_one <= 6'h32) else $error("bad ratio");
  a_freq_range: assert property (cur_in_start_freq <= 32'h00009c40)
    else $error("frequency out of range");
  a_pct_order: assert property (cur_in_start_pct <= cur_in_end_pct
    && cur_in_end_pct <= 7'h64) else $error("percent order");
  a_bip_order: assert property ($signed(bipolar_in_start_pct)
    <= $signed(bipolar_in_end_pct)) else $error("bipolar order");
  a_hold_nowrite: assert property (!(pready && pwrite && !pslverr) |=>
    $stable(source_combine_op) && $stable(decel_curve_shape)) else $error("spurious change");
endmodule

bind dspb_bank dspb_bank_checker u_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .src_first_freq, .src_second_freq, .target_freq,
  .decel_curve_shape, .cur_in_start_freq, .cur_in_start_pct, .cur_in_end_pct,
  .bipolar_in_start_pct, .bipolar_in_end_pct, .accel_curve_constant,
  .source_combine_op, .added_freq_offset, .added_freq_sign, .els_ratio_one);
`default_nettype wire

// ===== testbench/dspb_host.sv
// Communication host model acting as APB master of the parameter bank
`timescale 1ns/1ps
`default_nettype none
module dspb_host (
  // Clock
  input  wire logic        pclk,
  // APB master
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [15:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end

  // One transfer; the bench watchdog ends a wait on a dead slave
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show garbage, not the last value
    paddr <= ~a;
    pwdata <= ~{16'h0000, d};
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_drive_setpoint_param_bank.sv
// Self-checking testbench of the drive setpoint parameter bank
`timescale 1ns/1ps
`default_nettype none
`include "dspb_defs.vh"
module tb_drive_setpoint_param_bank;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, cur_in_start_freq, bipolar_in_start_freq;
  logic [15:0] src_first_freq = 16'd300;
  logic [15:0] src_second_freq = 16'd100;
  logic [33:0] target_freq, e34;
  logic [2:0]  freq_source_second;
  logic [31:0] r;
  logic        er;
  int          mismatches = 0;
  int          cmp_count = 0;
  logic [13:0] tix [12] = '{`DSPB_IX_DECEL_SHAPE, `DSPB_IX_ACC_CONST, `DSPB_IX_DEC_CONST,
    `DSPB_IX_SRC_FIRST, `DSPB_IX_SRC_SECOND, `DSPB_IX_COMBINE_OP, `DSPB_IX_ADD_SIGN,
    `DSPB_IX_CUR_SF_SEL, `DSPB_IX_ELS_R1, `DSPB_IX_ELS_R2, `DSPB_IX_ELS_DR1, `DSPB_IX_ELS_DR2};
  logic [15:0] tgood [12] = '{4, 10, 10, 7, 7, 2, 1, 1, 50, 50, 50, 50};
  logic [15:0] tbad [12] = '{5, 11, 0, 8, 8, 3, 2, 2, 51, 51, 51, 51};

  always #20 pclk = ~pclk;

  dspb_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  dspb_bank dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .src_first_freq, .src_second_freq, .target_freq,
    .decel_curve_shape(), .cur_in_start_freq, .cur_in_end_freq(), .cur_in_start_pct(),
    .cur_in_end_pct(), .cur_in_start_freq_select(), .bipolar_in_start_freq,
    .bipolar_in_end_freq(), .bipolar_in_start_pct(), .bipolar_in_end_pct(),
    .accel_curve_constant(), .decel_curve_constant(), .freq_source_first(),
    .freq_source_second, .source_combine_op(), .added_freq_offset(), .added_freq_sign(),
    .els_ratio_one(), .els_ratio_two(), .els_decel_ratio_one(), .els_decel_ratio_two());

  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [13:0] ix, input logic [15:0] d, input logic e);
    u_host.xfer(1'b1, {ix, 2'b00}, d, r, er);
    chk(er, e);
  endtask

  task automatic rd(input logic [13:0] ix, input logic [15:0] e);
    u_host.xfer(1'b0, {ix, 2'b00}, 16'h0000, r, er);
    chk(er, 1'b0);
    chk(r, {16'h0000, e});
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DSPB_IX_CUR_EPCT, 16'h0064);
    rd(`DSPB_IX_BIP_SPCT, 16'hff9c);
    rd(`DSPB_IX_ACC_CONST, 16'h0001);
    for (int i = 0; i < 12; i++) begin
      wr(tix[i], tgood[i], 1'b0);
      wr(tix[i], tbad[i], 1'b1);
      rd(tix[i], tgood[i]);
    end
    wr(`DSPB_IX_ACC_CONST, 16'h0000, 1'b1);
    for (int c = 0; c < 8; c++) begin
      wr(`DSPB_IX_SRC_SECOND, c[15:0], 1'b0);
      rd(`DSPB_IX_SRC_SECOND, c[15:0]);
      chk(freq_source_second, c[2:0]);
    end
    // Offset pair: a refused low word leaves the stored low word at 0 until a valid one lands
    wr(`DSPB_IX_ADD_HI, 16'h0000, 1'b0);
    wr(`DSPB_IX_ADD_LO, 16'h9c41, 1'b1);
    rd(`DSPB_IX_ADD_LO, 16'h0000);
    wr(`DSPB_IX_ADD_LO, 16'h9c40, 1'b0);
    rd(`DSPB_IX_ADD_LO, 16'h9c40);
    for (int op = 0; op < 3; op++) begin
      for (int sg = 0; sg < 2; sg++) begin
        wr(`DSPB_IX_COMBINE_OP, op[15:0], 1'b0);
        wr(`DSPB_IX_ADD_SIGN, sg[15:0], 1'b0);
        repeat (3) @(posedge pclk);
        #1;
        e34 = (op == 0) ? 34'd400 : (op == 1) ? 34'd200 : 34'd30000;
        e34 = sg ? e34 - 34'd40000 : e34 + 34'd40000;
        chk(target_freq, e34);
      end
    end
    wr(`DSPB_IX_CUR_SF_HI, 16'h0000, 1'b0);
    wr(`DSPB_IX_CUR_SF_LO, 16'h9c40, 1'b0);
    #1;
    chk(cur_in_start_freq, 32'h00009c40);
    wr(`DSPB_IX_CUR_EF_HI, 16'h0000, 1'b0);
    wr(`DSPB_IX_CUR_EF_LO, 16'h9c41, 1'b1);
    wr(`DSPB_IX_CUR_SPCT, 16'd60, 1'b0);
    wr(`DSPB_IX_CUR_EPCT, 16'd59, 1'b1);
    wr(`DSPB_IX_CUR_EPCT, 16'd60, 1'b0);
    wr(`DSPB_IX_CUR_SPCT, 16'd61, 1'b1);
    wr(`DSPB_IX_CUR_EPCT, 16'd101, 1'b1);
    rd(`DSPB_IX_CUR_EPCT, 16'd60);
    wr(`DSPB_IX_BIP_SF_HI, 16'hffff, 1'b0);
    wr(`DSPB_IX_BIP_SF_LO, 16'h63c0, 1'b0);
    rd(`DSPB_IX_BIP_SF_HI, 16'hffff);
    chk(bipolar_in_start_freq, 32'hffff63c0);
    wr(`DSPB_IX_BIP_EF_HI, 16'hffff, 1'b0);
    wr(`DSPB_IX_BIP_EF_LO, 16'h63bf, 1'b1);
    wr(`DSPB_IX_BIP_EPCT, 16'hff9b, 1'b1);
    wr(`DSPB_IX_BIP_SPCT, 16'h0032, 1'b0);
    wr(`DSPB_IX_BIP_EPCT, 16'h0031, 1'b1);
    wr(`DSPB_IX_BIP_SPCT, 16'h0065, 1'b1);
    u_host.xfer(1'b0, 16'h49fc, 16'h0000, r, er);
    chk({er, r}, 33'h100000000);
    u_host.xfer(1'b1, 16'h4ac8, 16'h0001, r, er);
    chk(er, 1'b1);
    u_host.xfer(1'b1, {`DSPB_IX_CUR_SPCT, 2'b01}, 16'h0005, r, er);
    chk(er, 1'b1);
    rd(`DSPB_IX_CUR_SPCT, 16'd60);
    // Enable low freezes the target although a source moves
    @(posedge pclk);
    ce <= 1'b0;
    src_first_freq <= 16'd500;
    repeat (4) @(posedge pclk);
    #1;
    chk(target_freq, e34);
    @(posedge pclk);
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk(target_freq, 34'd10000);
    // Mid-run reset brings back the defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DSPB_IX_COMBINE_OP, 16'h0000);
    rd(`DSPB_IX_BIP_EPCT, 16'h0064);
    rd(`DSPB_IX_DEC_CONST, 16'h0001);
    chk(target_freq, 34'd600);
    report_and_stop();
  end
endmodule
`default_nettype wire
